// ==== logic/dpa_defines.vh ====
`ifndef DPA_DEFINES_VH
`define DPA_DEFINES_VH

// Clock period of clk_i in ns.
`define DPA_CLK_NS 5

// Port timing in ns.
`define DPA_STROBE_AFTER_HOLD_RELEASE_NS 13
`define DPA_TOKEN_UPDATE_GAP_NS 10
`define DPA_TOKEN_WRITE_TO_READ_GAP_NS 5
`define DPA_WRITE_PULSE_NS 12
`define DPA_CROSS_PORT_DATA_DELAY_NS 25

// A read waits two extra cycles for the data synchroniser stages.
`define DPA_RD_SYNC_CYC 2

// Least times round up to whole cycles.
`define DPA_CEIL_CYC(ns) (((ns) + `DPA_CLK_NS - 1) / `DPA_CLK_NS)

// Register byte offsets.
`define DPA_OFS_CTRL 12'h000
`define DPA_OFS_ADDR 12'h004
`define DPA_OFS_WDATA 12'h008
`define DPA_OFS_RDATA 12'h00C
`define DPA_OFS_STATUS 12'h010

// Control register fields.
`define DPA_CTRL_START 0
`define DPA_CTRL_OP_LO 1
`define DPA_CTRL_OP_HI 2
`define DPA_CTRL_ROLE 4
`define DPA_ROLE_RST 1'b1

// Operation codes.
`define DPA_OP_MEM_RD 2'h0
`define DPA_OP_MEM_WR 2'h1
`define DPA_OP_TOK_RD 2'h2
`define DPA_OP_TOK_WR 2'h3

// Status register fields.
`define DPA_ST_ACTIVE 0
`define DPA_ST_DONE 1
`define DPA_ST_HOLD 2
`define DPA_ST_MAILBOX 3

// Token latches are picked by the lowest address lines.
`define DPA_TOK_AW 3

`endif

// ==== logic/dpa_sync.v ====
module dpa_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire clk_i, // Clock.
  input wire rst_i, // Async reset, active high.
  input wire [W-1:0] d_i, // Asynchronous input.
  output wire [W-1:0] q_o // Synchronised output.
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // The first stage feeds the second stage only.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule // dpa_sync

// ==== logic/dpa_port_ctrl.v ====
// Functional notes
// - A write happens while select and write strobe are low; rising edge ends it.
// - Write strobe stays high whenever this controller changes the address lines.
// - Memory access uses chip select low; token access uses token select low.
// - A held write keeps its strobe low at least 13 ns after hold rises.
// - After a token write, keep token select high 10 ns before verifying read.
// - Allow 5 ns between a token write end and the verifying read.
`include "dpa_defines.vh"
module dpa_port_ctrl #(
  parameter AW = 12,
  parameter DW = 9,
  parameter PULSE_NS = `DPA_WRITE_PULSE_NS,
  parameter ACCESS_NS = `DPA_CROSS_PORT_DATA_DELAY_NS
) (
  input wire clk_i, // Clock, 200 MHz.
  input wire rst_i, // Async reset, active high.
  input wire psel_i, // APB select.
  input wire penable_i, // APB enable.
  input wire pwrite_i, // APB direction, high for write.
  input wire [11:0] paddr_i, // APB byte address.
  input wire [31:0] pwdata_i, // APB write data.
  output wire [31:0] prdata_o, // APB read data.
  output wire pready_o, // APB ready, always high.
  output wire pslverr_o, // APB error on unmapped address.
  output reg [AW-1:0] mem_addr_o, // Address lines to the memory port.
  output reg mem_ce_n_o, // Chip select, active low.
  output reg mem_tok_n_o, // Token latch select, active low.
  output reg mem_rw_n_o, // Write strobe, low for write.
  output reg mem_oe_n_o, // Output enable, active low.
  output reg [DW-1:0] mem_data_o, // Data driven to the port.
  output reg mem_data_oe_o, // High while this side drives the data pins.
  input wire [DW-1:0] mem_data_i, // Data pins as seen.
  input wire mem_hold_n_i, // Hold line from the port, active low.
  input wire mem_mailbox_n_i, // Mailbox flag of this port, active low.
  output wire mem_role_o // Role select, high for master.
);
  localparam integer PULSE_CYC = `DPA_CEIL_CYC(PULSE_NS);
  localparam integer RELEASE_CYC = `DPA_CEIL_CYC(`DPA_STROBE_AFTER_HOLD_RELEASE_NS);
  localparam integer WR_CYC = (PULSE_CYC > RELEASE_CYC) ? PULSE_CYC : RELEASE_CYC;
  localparam integer RD_CYC = `DPA_CEIL_CYC(ACCESS_NS) + `DPA_RD_SYNC_CYC;
  localparam integer GAP_A = `DPA_CEIL_CYC(`DPA_TOKEN_UPDATE_GAP_NS);
  localparam integer GAP_B = `DPA_CEIL_CYC(`DPA_TOKEN_WRITE_TO_READ_GAP_NS);
  localparam integer GAP_CYC = (GAP_A > GAP_B) ? GAP_A : GAP_B;
  localparam [7:0] WR_LOAD = WR_CYC[7:0];
  localparam [7:0] RD_LOAD = RD_CYC[7:0];
  localparam [7:0] GAP_LOAD = GAP_CYC[7:0];

  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_SETUP = 5'h02;
  localparam [4:0] S_ACT = 5'h04;
  localparam [4:0] S_REL = 5'h08;
  localparam [4:0] S_GAP = 5'h10;

  reg [4:0] state_ff, nxt_state;
  reg [7:0] cnt_ff, nxt_cnt;
  reg [1:0] op_ff;
  reg role_ff;
  reg [AW-1:0] addr_ff;
  reg [DW-1:0] wdata_ff;
  reg [DW-1:0] rdata_ff;
  reg done_ff;
  wire [DW-1:0] data_sync;
  wire hold_n_sync;
  wire mailbox_n_sync;

  dpa_sync #(
    .W(DW + 2),
    .RST_VAL({{DW{1'b0}}, 2'b11})
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({mem_data_i, mem_hold_n_i, mem_mailbox_n_i}),
    .q_o({data_sync, hold_n_sync, mailbox_n_sync})
  );

  function is_write;
    input [1:0] op;
    begin
      is_write = (op == `DPA_OP_MEM_WR) || (op == `DPA_OP_TOK_WR);
    end
  endfunction

  function is_token;
    input [1:0] op;
    begin
      is_token = (op == `DPA_OP_TOK_RD) || (op == `DPA_OP_TOK_WR);
    end
  endfunction

  wire wr_en = psel_i & penable_i & pwrite_i;
  wire idle = state_ff[0];
  wire start = wr_en && (paddr_i == `DPA_OFS_CTRL) && pwdata_i[`DPA_CTRL_START] && idle;
  wire [1:0] start_op = pwdata_i[`DPA_CTRL_OP_HI:`DPA_CTRL_OP_LO];
  wire finish = state_ff[4] && (cnt_ff == 8'h00);
  wire clr_done = wr_en && (paddr_i == `DPA_OFS_STATUS) && pwdata_i[`DPA_ST_DONE];

  // A start while an access runs is ignored; software polls the active bit.
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      S_IDLE: begin
        if (start) begin
          nxt_state = S_SETUP;
        end
      end
      S_SETUP: begin
        nxt_state = S_ACT;
        nxt_cnt = is_write(op_ff) ? WR_LOAD : RD_LOAD;
      end
      S_ACT: begin
        if (!hold_n_sync) begin
          // While held, restart the count so the strobe outlasts the release.
          nxt_cnt = is_write(op_ff) ? WR_LOAD : RD_LOAD;
        end else if (cnt_ff > 8'h01) begin
          nxt_cnt = cnt_ff - 8'h01;
        end else begin
          nxt_state = is_write(op_ff) ? S_REL : S_GAP;
          nxt_cnt = GAP_LOAD;
        end
      end
      S_REL: begin
        nxt_state = S_GAP;
        nxt_cnt = GAP_LOAD;
      end
      S_GAP: begin
        if (cnt_ff != 8'h00) begin
          nxt_cnt = cnt_ff - 8'h01;
        end else begin
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
        nxt_cnt = 8'h00;
      end
    endcase
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= S_IDLE;
      cnt_ff <= 8'h00;
      op_ff <= `DPA_OP_MEM_RD;
      role_ff <= `DPA_ROLE_RST;
      addr_ff <= {AW{1'b0}};
      wdata_ff <= {DW{1'b0}};
      rdata_ff <= {DW{1'b0}};
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      if (wr_en && (paddr_i == `DPA_OFS_CTRL)) begin
        role_ff <= pwdata_i[`DPA_CTRL_ROLE];
        if (idle) begin
          op_ff <= pwdata_i[`DPA_CTRL_OP_HI:`DPA_CTRL_OP_LO];
        end
      end
      if (wr_en && (paddr_i == `DPA_OFS_ADDR) && idle) begin
        addr_ff <= pwdata_i[AW-1:0];
      end
      if (wr_en && (paddr_i == `DPA_OFS_WDATA) && idle) begin
        wdata_ff <= pwdata_i[DW-1:0];
      end
      // Read data is taken at the end of the access wait, after the cross-port delay.
      if (state_ff[2] && (nxt_state == S_GAP) && !is_write(op_ff)) begin
        rdata_ff <= data_sync;
      end
      // Completion set wins over a software clear in the same cycle.
      if (finish) begin
        done_ff <= 1'b1;
      end else if (clr_done) begin
        done_ff <= 1'b0;
      end
    end
  end

  // Pin drive. Address moves only in idle, with the strobe high.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_addr_o <= {AW{1'b0}};
      mem_ce_n_o <= 1'b1;
      mem_tok_n_o <= 1'b1;
      mem_rw_n_o <= 1'b1;
      mem_oe_n_o <= 1'b1;
      mem_data_o <= {DW{1'b0}};
      mem_data_oe_o <= 1'b0;
    end else begin
      mem_ce_n_o <= 1'b1;
      mem_tok_n_o <= 1'b1;
      mem_rw_n_o <= 1'b1;
      mem_oe_n_o <= 1'b1;
      mem_data_oe_o <= 1'b0;
      if (nxt_state == S_SETUP) begin
        // The op register loads on this same edge, so the new op is decoded from the bus.
        mem_addr_o <= is_token(start_op) ? {{(AW - `DPA_TOK_AW){1'b0}},
          addr_ff[`DPA_TOK_AW-1:0]} : addr_ff;
        mem_data_o <= is_token(start_op) ? {{(DW - 1){1'b0}}, wdata_ff[0]} : wdata_ff;
      end
      if (nxt_state == S_ACT) begin
        mem_ce_n_o <= is_token(op_ff);
        mem_tok_n_o <= ~is_token(op_ff);
        mem_rw_n_o <= ~is_write(op_ff);
        mem_oe_n_o <= is_write(op_ff);
        mem_data_oe_o <= is_write(op_ff);
      end
      // Strobe rises first while select and data stay, so data holds past the edge.
      if (nxt_state == S_REL) begin
        mem_ce_n_o <= is_token(op_ff);
        mem_tok_n_o <= ~is_token(op_ff);
        mem_data_oe_o <= 1'b1;
      end
    end
  end

  assign mem_role_o = role_ff;

  reg [31:0] rd_mux;
  reg rd_err;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr_i)
      `DPA_OFS_CTRL: begin
        rd_mux[`DPA_CTRL_OP_HI:`DPA_CTRL_OP_LO] = op_ff;
        rd_mux[`DPA_CTRL_ROLE] = role_ff;
      end
      `DPA_OFS_ADDR: rd_mux[AW-1:0] = addr_ff;
      `DPA_OFS_WDATA: rd_mux[DW-1:0] = wdata_ff;
      `DPA_OFS_RDATA: rd_mux[DW-1:0] = rdata_ff;
      `DPA_OFS_STATUS: begin
        rd_mux[`DPA_ST_ACTIVE] = ~idle;
        rd_mux[`DPA_ST_DONE] = done_ff;
        rd_mux[`DPA_ST_HOLD] = ~hold_n_sync;
        rd_mux[`DPA_ST_MAILBOX] = ~mailbox_n_sync;
      end
      default: rd_err = 1'b1;
    endcase
  end

  assign prdata_o = (psel_i && !pwrite_i) ? rd_mux : 32'h0000_0000;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & rd_err;
endmodule // dpa_port_ctrl

// ==== bench/dpa_checker.sv ====
module dpa_checker #(
  parameter AW = 12,
  parameter DW = 9
) (
  input wire clk_i, // Clock.
  input wire rst_i, // Reset.
  input wire [AW-1:0] mem_addr_o, // Address.
  input wire mem_ce_n_o, // Chip select.
  input wire mem_tok_n_o, // Token select.
  input wire mem_rw_n_o, // Write strobe.
  input wire mem_oe_n_o, // Output enable.
  input wire [DW-1:0] mem_data_o, // Write data.
  input wire mem_data_oe_o, // Data drive.
  input wire mem_hold_n_i // Hold line.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_sel_excl; !(!mem_ce_n_o && !mem_tok_n_o); endproperty
  a_sel_excl: assert property (p_sel_excl) else $error("both selects low");
  property p_addr_quiet; $changed(mem_addr_o) |-> mem_rw_n_o && $past(mem_rw_n_o); endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("address moved in write");
  property p_wr_pulse; $fell(mem_rw_n_o) |-> !mem_rw_n_o [*3]; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse short");
  property p_wr_drive; !mem_rw_n_o |-> mem_data_oe_o && mem_oe_n_o; endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write without drive");
  property p_data_hold; $rose(mem_rw_n_o) |-> $stable(mem_data_o) && mem_data_oe_o; endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved at write end");
  property p_end_sel; $rose(mem_rw_n_o) |-> !mem_ce_n_o || !mem_tok_n_o; endproperty
  a_end_sel: assert property (p_end_sel) else $error("select left before strobe");
  property p_hold_wr; $rose(mem_hold_n_i) && !mem_rw_n_o |=> !mem_rw_n_o [*3]; endproperty
  a_hold_wr: assert property (p_hold_wr) else $error("held write ended early");
  property p_tok_gap; $rose(mem_tok_n_o) |-> (mem_tok_n_o && mem_ce_n_o) [*2]; endproperty
  a_tok_gap: assert property (p_tok_gap) else $error("token gap short");
  property p_tok_addr; !mem_tok_n_o |-> mem_addr_o[AW-1:3] == '0; endproperty
  a_tok_addr: assert property (p_tok_addr) else $error("token address high bits");
endmodule // dpa_checker

bind dpa_port_ctrl dpa_checker #(.AW(AW), .DW(DW)) i_dpa_checker (.*);

// ==== bench/dpa_mem_model.sv ====
module dpa_mem_model (
  input wire logic [11:0] addr_i, // Address.
  input wire logic ce_n_i, // Chip select.
  input wire logic tok_n_i, // Token select.
  input wire logic rw_n_i, // Write strobe.
  input wire logic oe_n_i, // Output enable.
  input wire logic [8:0] wd_i, // Host data.
  input wire logic wd_oe_i, // Host drives.
  input wire logic busy_i, // Far port on same word.
  input wire logic mbox_set_i, // Far port posts mail.
  output logic [8:0] pins_o, // Data pins.
  output logic hold_n_o, // Hold line.
  output logic mbox_n_o // Mailbox flag.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] mem [0:4095];
  logic [7:0] tok = 8'hFF;
  logic [8:0] last = 9'h000;
  wire drv = !oe_n_i && rw_n_i && (ce_n_i ^ tok_n_i);
  initial mbox_n_o = 1'b1;
  assign hold_n_o = !(busy_i && !ce_n_i);
  always @(posedge rw_n_i) begin
    if (!ce_n_i && hold_n_o) mem[addr_i] <= wd_i;
    if (!tok_n_i) tok[addr_i[2:0]] <= wd_i[0];
  end
  // Released pins show the inverse of the last level, so no stale value passes.
  assign pins_o = wd_oe_i ? wd_i :
    drv ? (tok_n_i ? mem[addr_i] : {9{tok[addr_i[2:0]]}}) : ~last;
  always @* if (wd_oe_i || drv) last = pins_o;
  always @* begin
    if (mbox_set_i) mbox_n_o = 1'b0;
    else if (drv && !ce_n_i && addr_i == 12'hFFE) mbox_n_o = 1'b1;
  end
endmodule // dpa_mem_model

// ==== bench/dpa_port_ctrl_bench.sv ====
`include "dpa_defines.vh"
module dpa_port_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic busy = 1'b0, mbox = 1'b0, perr, pready_o, pslverr_o;
  logic ce_n, tok_n, rw_n, oe_n, doe, hold_n, mbox_n, role;
  logic [11:0] paddr_i = 12'h000, addr;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, r;
  logic [8:0] wd, pins;
  int err_count = 0, checks = 0;
  dpa_port_ctrl i_dpa_port_ctrl (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_addr_o(addr),
    .mem_ce_n_o(ce_n), .mem_tok_n_o(tok_n), .mem_rw_n_o(rw_n), .mem_oe_n_o(oe_n),
    .mem_data_o(wd), .mem_data_oe_o(doe), .mem_data_i(pins), .mem_hold_n_i(hold_n),
    .mem_mailbox_n_i(mbox_n), .mem_role_o(role));
  dpa_mem_model i_dpa_mem_model (.addr_i(addr), .ce_n_i(ce_n), .tok_n_i(tok_n), .rw_n_i(rw_n),
    .oe_n_i(oe_n), .wd_i(wd), .wd_oe_i(doe), .busy_i(busy), .mbox_set_i(mbox),
    .pins_o(pins), .hold_n_o(hold_n), .mbox_n_o(mbox_n));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic op(input logic [1:0] o, input logic [11:0] a, input logic [8:0] d);
    apb(1'b1, `DPA_OFS_ADDR, {20'h0_0000, a});
    apb(1'b1, `DPA_OFS_WDATA, {23'h00_0000, d});
    apb(1'b1, `DPA_OFS_CTRL, {27'h000_0000, 1'b1, 1'b0, o, 1'b1});
  endtask
  // Polls done, clears it and leaves the captured read word in r.
  task automatic wait_done;
    int n;
    n = 0;
    r = 32'h0000_0000;
    while (r[`DPA_ST_DONE] !== 1'b1 && n < 100) begin
      apb(1'b0, `DPA_OFS_STATUS, 32'h0000_0000);
      n++;
    end
    chk(32'h0000_0002, r & 32'h0000_0003);
    apb(1'b1, `DPA_OFS_STATUS, 32'h0000_0002);
    apb(1'b0, `DPA_OFS_RDATA, 32'h0000_0000);
  endtask
  task automatic t_regs;
    apb(1'b0, `DPA_OFS_CTRL, 32'h0000_0000);
    chk(32'h0000_0010, r);
    chk(32'h0000_0001, {31'h0000_0000, role});
    apb(1'b1, `DPA_OFS_CTRL, 32'h0000_0000);
    apb(1'b0, `DPA_OFS_CTRL, 32'h0000_0000);
    chk(32'h0000_0000, r);
    chk(32'h0000_0000, {31'h0000_0000, role});
    apb(1'b1, `DPA_OFS_CTRL, 32'h0000_0010);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk(32'h0000_0001, {31'h0000_0000, perr});
  endtask
  task automatic t_mem;
    op(`DPA_OP_MEM_WR, 12'hFFF, 9'h1A5);
    wait_done;
    op(`DPA_OP_MEM_WR, 12'h000, 9'h05A);
    wait_done;
    op(`DPA_OP_MEM_RD, 12'hFFF, 9'h000);
    wait_done;
    chk(32'h0000_01A5, r);
    op(`DPA_OP_MEM_RD, 12'h000, 9'h000);
    wait_done;
    chk(32'h0000_005A, r);
  endtask
  task automatic t_tok;
    op(`DPA_OP_TOK_WR, 12'h005, 9'h000);
    wait_done;
    op(`DPA_OP_TOK_RD, 12'h005, 9'h000);
    wait_done;
    chk(32'h0000_0000, r);
    op(`DPA_OP_TOK_RD, 12'h004, 9'h000);
    wait_done;
    chk(32'h0000_01FF, r);
    op(`DPA_OP_TOK_WR, 12'h005, 9'h001);
    wait_done;
    op(`DPA_OP_TOK_RD, 12'h005, 9'h000);
    wait_done;
    chk(32'h0000_01FF, r);
  endtask
  task automatic t_hold;
    busy <= 1'b1;
    op(`DPA_OP_MEM_WR, 12'h010, 9'h0C3);
    repeat (20) apb(1'b0, `DPA_OFS_STATUS, 32'h0000_0000);
    chk(32'h0000_0005, r);
    busy <= 1'b0;
    wait_done;
    op(`DPA_OP_MEM_RD, 12'h010, 9'h000);
    wait_done;
    chk(32'h0000_00C3, r);
  endtask
  task automatic t_mbox;
    mbox <= 1'b1;
    apb(1'b0, `DPA_OFS_STATUS, 32'h0000_0000);
    mbox <= 1'b0;
    apb(1'b0, `DPA_OFS_STATUS, 32'h0000_0000);
    chk(32'h0000_0008, r);
    op(`DPA_OP_MEM_RD, 12'hFFE, 9'h000);
    wait_done;
    apb(1'b0, `DPA_OFS_STATUS, 32'h0000_0000);
    chk(32'h0000_0000, r);
  endtask
  task automatic give_verdict;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_mem;
    t_tok;
    t_hold;
    t_mbox;
    give_verdict;
  end
  // The scenarios need a few hundred cycles; this leaves ample margin.
  initial begin
    #50000;
    err_count++;
    give_verdict;
  end
endmodule // dpa_port_ctrl_bench
